// File: hdl/canmc_mode_ctrl.sv
`timescale 1ns/1ps
//
// Overview of operation
// - Handles 11-bit standard and 29-bit extended frames automatically.
// - Three transmit mailboxes, ordered by identifier or by request order.
// - Two hardware receive FIFOs, three messages deep each.
// - Fourteen filter groups; matching frames kept, others dropped.
// - Time-triggered mode: 16-bit timer runs, retransmission off, timestamp bytes.
// - Hardware reset starts in sleep with transmit pull-up on.
// - Pull-up off once init or sleep acknowledge is shown.
// - Normal when both acks low; needs 11 recessive bits first.
// - Init entry/exit by request and acknowledge; registers unchanged.
// - In init no traffic, transmit pin held recessive.
// - No reception while filter init flag is set.
// - Sleep by request and acknowledge; core clock stops, registers reachable.
// - Auto wake-up clears sleep request on bus activity.
// - Wake-up interrupt on bus activity when enabled, either wake mode.
// - Test mode bits chosen only in init, entered on leaving init.
// - Loopback: transmit fed to receive, pin ignored, ack errors ignored.
// - Silent: receive normally, bus sees only recessive bits.
// - Loopback-silent: receive pin cut off, transmit pin recessive.
// - Debug halt freezes or runs per freeze bit and external stop.
//
module canmc_mode_ctrl #(
  parameter int TX_MAILBOXES = 3,
  parameter int RX_FIFOS = 2,
  parameter int RX_FIFO_DEPTH = 3,
  parameter int FILTER_GROUPS = 14,
  parameter int TIMER_WIDTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic bus_rx_pin,
  output logic bus_tx_pin,
  output logic tx_pullup_en,
  input wire logic core_tx,
  output logic core_rx,
  output logic core_clk_en,
  output logic tx_enable,
  output logic rx_enable,
  output logic ack_err_ignore,
  output logic auto_retx_en,
  output logic tx_order_by_request,
  output logic timestamp_en,
  output logic [TIMER_WIDTH-1:0] ttc_timer,
  output logic [FILTER_GROUPS-1:0] filter_active,
  output logic wakeup_irq,
  input wire logic debug_halt,
  input wire logic debug_stop_en
);

  // ----------------------------------------------------------------
  // Bus slave address phase
  // ----------------------------------------------------------------
  canmc_pkg::canmc_aphase_t aph_ff;
  canmc_pkg::canmc_aphase_t nxt_aph;
  logic wr_ctrl;
  logic wr_status;
  logic wr_int_en;
  logic wr_bit_timing;
  logic wr_filter_ctrl;
  logic wr_filter_act;

  always_comb begin
    nxt_aph.valid = hsel & hready & htrans[1];
    nxt_aph.write = hwrite;
    nxt_aph.addr = {haddr[11:2], 2'h0};
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aph_ff <= '0;
    end else if (hready) begin
      aph_ff <= nxt_aph;
    end
  end

  wire logic wr_hit = aph_ff.valid & aph_ff.write;
  assign wr_ctrl = wr_hit & (aph_ff.addr == canmc_pkg::OFS_MASTER_CTRL);
  assign wr_status = wr_hit & (aph_ff.addr == canmc_pkg::OFS_MASTER_STATUS);
  assign wr_int_en = wr_hit & (aph_ff.addr == canmc_pkg::OFS_INT_ENABLE);
  assign wr_bit_timing = wr_hit & (aph_ff.addr == canmc_pkg::OFS_BIT_TIMING);
  assign wr_filter_ctrl = wr_hit & (aph_ff.addr == canmc_pkg::OFS_FILTER_CTRL);
  assign wr_filter_act = wr_hit & (aph_ff.addr == canmc_pkg::OFS_FILTER_ACT);

  // ----------------------------------------------------------------
  // Control and configuration registers
  // ----------------------------------------------------------------
  canmc_pkg::canmc_ctrl_t ctrl_ff;
  canmc_pkg::canmc_mode_t mode_ff;
  canmc_pkg::canmc_mode_t nxt_mode;
  logic [31:0] bit_timing_ff;
  logic wake_irq_en_ff;
  logic filter_init_ff;
  logic [FILTER_GROUPS-1:0] filter_act_ff;
  logic wakeup_flag_ff;
  logic init_ack_ff;
  logic sleep_ack_ff;

  // Dominant level on the receive pin while asleep counts as activity
  wire logic bus_activity = (mode_ff == canmc_pkg::CANMC_SLEEP) & ~bus_rx_pin;
  wire logic frozen = debug_halt & debug_stop_en & ctrl_ff.debug_freeze;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= '{sleep_request: 1'b1, default: 1'b0};
    end else if (wr_ctrl) begin
      // A software write wins over the hardware wake-up clear
      ctrl_ff.init_request <= hwdata[canmc_pkg::MC_INIT_REQ];
      ctrl_ff.sleep_request <= hwdata[canmc_pkg::MC_SLEEP_REQ];
      ctrl_ff.tx_order_by_request <= hwdata[canmc_pkg::MC_TX_ORDER];
      ctrl_ff.no_auto_retx <= hwdata[canmc_pkg::MC_NO_RETX];
      ctrl_ff.auto_wakeup <= hwdata[canmc_pkg::MC_AUTO_WAKE];
      ctrl_ff.time_trig <= hwdata[canmc_pkg::MC_TIME_TRIG];
      ctrl_ff.debug_freeze <= hwdata[canmc_pkg::MC_DBG_FREEZE];
    end else if (bus_activity & ctrl_ff.auto_wakeup) begin
      ctrl_ff.sleep_request <= 1'b0;
    end
  end

  // Timing and test selection can only be written while in init
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_timing_ff <= canmc_pkg::RST_BIT_TIMING;
    end else if (wr_bit_timing & (mode_ff == canmc_pkg::CANMC_INIT)) begin
      bit_timing_ff <= hwdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wake_irq_en_ff <= 1'b0;
    end else if (wr_int_en) begin
      wake_irq_en_ff <= hwdata[canmc_pkg::IE_WAKEUP];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      filter_init_ff <= canmc_pkg::RST_FILTER_CTRL[canmc_pkg::FC_FILTER_INIT];
    end else if (wr_filter_ctrl) begin
      filter_init_ff <= hwdata[canmc_pkg::FC_FILTER_INIT];
    end
  end

  // Filter activation is writable in any mode; edits of values are the caller's care
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      filter_act_ff <= '0;
    end else if (wr_filter_act) begin
      filter_act_ff <= hwdata[FILTER_GROUPS-1:0];
    end
  end

  // Sticky wake event; a new event in the clearing cycle survives
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wakeup_flag_ff <= 1'b0;
    end else if (bus_activity) begin
      wakeup_flag_ff <= 1'b1;
    end else if (wr_status & hwdata[canmc_pkg::MS_WAKEUP]) begin
      wakeup_flag_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Bit time base
  // ----------------------------------------------------------------
  logic [9:0] tq_cnt_ff;
  logic [4:0] bit_cnt_ff;
  logic tq_tick;
  logic bit_tick;
  logic [4:0] quanta_per_bit;

  always_comb begin
    quanta_per_bit = 5'h3 + {1'b0, bit_timing_ff[canmc_pkg::BT_TS1_LSB +: 4]}
      + {2'h0, bit_timing_ff[canmc_pkg::BT_TS2_LSB +: 3]};
    tq_tick = (tq_cnt_ff == bit_timing_ff[canmc_pkg::BT_PRESC_LSB +: 10]);
    bit_tick = tq_tick & (bit_cnt_ff == (quanta_per_bit - 5'h1));
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tq_cnt_ff <= '0;
      bit_cnt_ff <= '0;
    end else if (mode_ff == canmc_pkg::CANMC_INIT || mode_ff == canmc_pkg::CANMC_SLEEP) begin
      tq_cnt_ff <= '0;
      bit_cnt_ff <= '0;
    end else if (!frozen) begin
      tq_cnt_ff <= tq_tick ? 10'h0 : tq_cnt_ff + 10'h1;
      bit_cnt_ff <= bit_tick ? 5'h0 : bit_cnt_ff + {4'h0, tq_tick};
    end
  end

  // ----------------------------------------------------------------
  // Mode state machine
  // ----------------------------------------------------------------
  logic [4:0] recessive_cnt_ff;

  // Sync watches the level the core would see, so loopback syncs on its own output
  wire logic rx_route = bit_timing_ff[canmc_pkg::BT_LOOPBACK] ? core_tx : bus_rx_pin;
  wire logic synced = (recessive_cnt_ff == canmc_pkg::SYNC_RECESSIVE_BITS);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      recessive_cnt_ff <= '0;
    end else if (mode_ff != canmc_pkg::CANMC_SYNC) begin
      recessive_cnt_ff <= '0;
    end else if (bit_tick & !frozen & !rx_route) begin
      recessive_cnt_ff <= '0;
    end else if (bit_tick & !frozen & !synced) begin
      recessive_cnt_ff <= recessive_cnt_ff + 5'h1;
    end
  end

  always_comb begin
    nxt_mode = mode_ff;
    unique case (mode_ff)
      canmc_pkg::CANMC_SLEEP: begin
        if (!ctrl_ff.sleep_request) begin
          nxt_mode = ctrl_ff.init_request ? canmc_pkg::CANMC_INIT : canmc_pkg::CANMC_SYNC;
        end
      end
      canmc_pkg::CANMC_INIT: begin
        if (!ctrl_ff.init_request) begin
          nxt_mode = ctrl_ff.sleep_request ? canmc_pkg::CANMC_SLEEP : canmc_pkg::CANMC_SYNC;
        end
      end
      canmc_pkg::CANMC_SYNC, canmc_pkg::CANMC_NORMAL: begin
        if (ctrl_ff.init_request) begin
          nxt_mode = canmc_pkg::CANMC_INIT;
        end else if (ctrl_ff.sleep_request) begin
          nxt_mode = canmc_pkg::CANMC_SLEEP;
        end else if (mode_ff == canmc_pkg::CANMC_SYNC && synced) begin
          nxt_mode = canmc_pkg::CANMC_NORMAL;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_ff <= canmc_pkg::CANMC_SLEEP;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      init_ack_ff <= 1'b0;
      sleep_ack_ff <= 1'b1;
    end else begin
      init_ack_ff <= (mode_ff == canmc_pkg::CANMC_INIT);
      sleep_ack_ff <= (mode_ff == canmc_pkg::CANMC_SLEEP);
    end
  end

  // Pull-up is released for good once the first acknowledge has been shown
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_pullup_en <= 1'b1;
    end else if (init_ack_ff | sleep_ack_ff) begin
      tx_pullup_en <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pin and core routing by mode
  // ----------------------------------------------------------------
  wire logic active = (mode_ff == canmc_pkg::CANMC_NORMAL);
  wire logic loopback = bit_timing_ff[canmc_pkg::BT_LOOPBACK];
  wire logic silent = bit_timing_ff[canmc_pkg::BT_SILENT];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_tx_pin <= 1'b1;
      core_rx <= 1'b1;
    end else if (!active) begin
      bus_tx_pin <= 1'b1;
      core_rx <= 1'b1;
    end else if (loopback & silent) begin
      bus_tx_pin <= 1'b1;
      core_rx <= core_tx;
    end else if (loopback) begin
      bus_tx_pin <= core_tx;
      core_rx <= core_tx;
    end else if (silent) begin
      bus_tx_pin <= 1'b1;
      core_rx <= bus_rx_pin & core_tx;
    end else begin
      bus_tx_pin <= core_tx;
      core_rx <= bus_rx_pin;
    end
  end

  // Frame engine gates; frame handling itself lives in the protocol core
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_clk_en <= 1'b0;
      tx_enable <= 1'b0;
      rx_enable <= 1'b0;
      ack_err_ignore <= 1'b0;
      auto_retx_en <= 1'b0;
      tx_order_by_request <= 1'b0;
      timestamp_en <= 1'b0;
      filter_active <= '0;
    end else begin
      core_clk_en <= (mode_ff != canmc_pkg::CANMC_SLEEP) & !frozen;
      tx_enable <= active & !frozen & !silent;
      rx_enable <= active & !frozen & !filter_init_ff;
      ack_err_ignore <= loopback;
      auto_retx_en <= !ctrl_ff.no_auto_retx & !ctrl_ff.time_trig;
      tx_order_by_request <= ctrl_ff.tx_order_by_request;
      timestamp_en <= ctrl_ff.time_trig;
      filter_active <= filter_init_ff ? '0 : filter_act_ff;
    end
  end

  // Free-running timer advances once per bit time
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ttc_timer <= '0;
    end else if (ctrl_ff.time_trig & bit_tick & !frozen) begin
      ttc_timer <= ttc_timer + {{(TIMER_WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wakeup_irq <= 1'b0;
    end else begin
      wakeup_irq <= wakeup_flag_ff & wake_irq_en_ff;
    end
  end

  // ----------------------------------------------------------------
  // Read data and response
  // ----------------------------------------------------------------
  logic [31:0] nxt_rdata;

  always_comb begin
    nxt_rdata = '0;
    if (nxt_aph.valid & !hwrite) begin
      unique case (nxt_aph.addr)
        canmc_pkg::OFS_MASTER_CTRL: begin
          nxt_rdata[canmc_pkg::MC_INIT_REQ] = ctrl_ff.init_request;
          nxt_rdata[canmc_pkg::MC_SLEEP_REQ] = ctrl_ff.sleep_request;
          nxt_rdata[canmc_pkg::MC_TX_ORDER] = ctrl_ff.tx_order_by_request;
          nxt_rdata[canmc_pkg::MC_NO_RETX] = ctrl_ff.no_auto_retx;
          nxt_rdata[canmc_pkg::MC_AUTO_WAKE] = ctrl_ff.auto_wakeup;
          nxt_rdata[canmc_pkg::MC_TIME_TRIG] = ctrl_ff.time_trig;
          nxt_rdata[canmc_pkg::MC_DBG_FREEZE] = ctrl_ff.debug_freeze;
        end
        canmc_pkg::OFS_MASTER_STATUS: begin
          nxt_rdata[canmc_pkg::MS_INIT_ACK] = init_ack_ff;
          nxt_rdata[canmc_pkg::MS_SLEEP_ACK] = sleep_ack_ff;
          nxt_rdata[canmc_pkg::MS_WAKEUP] = wakeup_flag_ff;
          nxt_rdata[canmc_pkg::MS_SYNCED] = active;
          nxt_rdata[canmc_pkg::MS_RX_LEVEL] = bus_rx_pin;
        end
        canmc_pkg::OFS_TIMER: nxt_rdata[TIMER_WIDTH-1:0] = ttc_timer;
        canmc_pkg::OFS_INT_ENABLE: nxt_rdata[canmc_pkg::IE_WAKEUP] = wake_irq_en_ff;
        canmc_pkg::OFS_BIT_TIMING: nxt_rdata = bit_timing_ff;
        canmc_pkg::OFS_FILTER_CTRL: nxt_rdata[canmc_pkg::FC_FILTER_INIT] = filter_init_ff;
        canmc_pkg::OFS_FILTER_ACT: nxt_rdata[FILTER_GROUPS-1:0] = filter_act_ff;
        default: nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hrdata <= hready ? nxt_rdata : hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

endmodule

// File: include/canmc_pkg.sv
package canmc_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_MASTER_CTRL = 12'h000;
  localparam logic [11:0] OFS_MASTER_STATUS = 12'h004;
  localparam logic [11:0] OFS_TIMER = 12'h008;
  localparam logic [11:0] OFS_INT_ENABLE = 12'h014;
  localparam logic [11:0] OFS_BIT_TIMING = 12'h01C;
  localparam logic [11:0] OFS_FILTER_CTRL = 12'h200;
  localparam logic [11:0] OFS_FILTER_ACT = 12'h21C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MC_INIT_REQ = 0;
  localparam int MC_SLEEP_REQ = 1;
  localparam int MC_TX_ORDER = 2;
  localparam int MC_NO_RETX = 4;
  localparam int MC_AUTO_WAKE = 5;
  localparam int MC_TIME_TRIG = 7;
  localparam int MC_DBG_FREEZE = 16;
  localparam int MS_INIT_ACK = 0;
  localparam int MS_SLEEP_ACK = 1;
  localparam int MS_WAKEUP = 3;
  localparam int MS_SYNCED = 4;
  localparam int MS_RX_LEVEL = 11;
  localparam int IE_WAKEUP = 16;
  localparam int BT_PRESC_LSB = 0;
  localparam int BT_TS1_LSB = 16;
  localparam int BT_TS2_LSB = 20;
  localparam int BT_LOOPBACK = 30;
  localparam int BT_SILENT = 31;
  localparam int FC_FILTER_INIT = 0;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_BIT_TIMING = 32'h0123_0000;
  localparam logic [31:0] RST_FILTER_CTRL = 32'h0000_0001;
  localparam logic [4:0] SYNC_RECESSIVE_BITS = 5'h0B;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum {CANMC_SLEEP, CANMC_INIT, CANMC_SYNC, CANMC_NORMAL} canmc_mode_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [11:0] addr;
  } canmc_aphase_t;

  typedef struct packed {
    logic debug_freeze;
    logic time_trig;
    logic auto_wakeup;
    logic no_auto_retx;
    logic tx_order_by_request;
    logic sleep_request;
    logic init_request;
  } canmc_ctrl_t;

endpackage

// File: sim/canmc_mode_ctrl_sva.sv
`timescale 1ns/1ps
module canmc_mode_ctrl_sva #(
  parameter int TIMER_WIDTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic bus_tx_pin,
  input wire logic tx_pullup_en,
  input wire logic core_tx,
  input wire logic core_rx,
  input wire logic core_clk_en,
  input wire logic tx_enable,
  input wire logic rx_enable,
  input wire logic ack_err_ignore,
  input wire logic auto_retx_en,
  input wire logic timestamp_en,
  input wire logic [TIMER_WIDTH-1:0] ttc_timer
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_pullup_rst;
    $fell(rst) |-> ##[0:2] !tx_pullup_en;
  endproperty
  a_pullup_rst: assert property (p_pullup_rst) else $error("pull-up still on");
  property p_pullup_once;
    !$rose(tx_pullup_en);
  endproperty
  a_pullup_once: assert property (p_pullup_once) else $error("pull-up came back");
  property p_tx_idle;
    !tx_enable [*2] |-> bus_tx_pin;
  endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("tx pin dominant");
  property p_retx;
    timestamp_en |-> !auto_retx_en;
  endproperty
  a_retx: assert property (p_retx) else $error("retransmit in time mode");
  property p_timer_step;
    timestamp_en && $past(timestamp_en) && $changed(ttc_timer)
      |-> ttc_timer == $past(ttc_timer) + 1'b1;
  endproperty
  a_timer_step: assert property (p_timer_step) else $error("timer step wrong");
  property p_timer_gap;
    timestamp_en && $changed(ttc_timer) |=> $stable(ttc_timer) [*2];
  endproperty
  a_timer_gap: assert property (p_timer_gap) else $error("timer too fast");
  property p_loop_route;
    $past(tx_enable) && $past(ack_err_ignore) && tx_enable
      |-> core_rx == $past(core_tx) && bus_tx_pin == $past(core_tx);
  endproperty
  a_loop_route: assert property (p_loop_route) else $error("loopback route wrong");
  property p_no_clk;
    !core_clk_en [*2] |-> !tx_enable && !rx_enable;
  endproperty
  a_no_clk: assert property (p_no_clk) else $error("traffic without clock");
  property p_okay;
    !hresp && hreadyout;
  endproperty
  a_okay: assert property (p_okay) else $error("bus response not okay");
  property p_idle_rdata;
    !$past(hsel) || !$past(hready) || !$past(htrans[1]) |-> hrdata == 32'h0;
  endproperty
  a_idle_rdata: assert property (p_idle_rdata) else $error("read data when idle");
  c_loop: cover property (tx_enable && ack_err_ignore);
  c_sleep: cover property ($fell(core_clk_en));
  c_timer: cover property (timestamp_en && $changed(ttc_timer));
endmodule

// File: sim/canmc_bus_node.sv
`timescale 1ns/1ps
module canmc_bus_node (
  input wire logic bus_tx_pin,
  input wire logic node_dominant,
  output logic bus_rx_pin
);
  // Wired-AND bus, recessive when no node pulls it
  assign bus_rx_pin = bus_tx_pin & ~node_dominant;
endmodule

// File: sim/canmc_mode_ctrl_tb_top.sv
`timescale 1ns/1ps
module canmc_mode_ctrl_tb_top;
  logic clk, rst, hsel, hwrite, dom, core_tx, debug_halt, debug_stop_en;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic hreadyout, hresp, bus_rx_pin, bus_tx_pin, tx_pullup_en, core_rx;
  logic core_clk_en, tx_enable, rx_enable, ack_err_ignore, auto_retx_en;
  logic tx_order_by_request, timestamp_en, wakeup_irq;
  logic [15:0] ttc_timer;
  logic [13:0] filter_active;
  int err_count, checks, cyc;
  canmc_mode_ctrl DUT (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hready(hreadyout), .hwdata, .hreadyout, .hresp, .hrdata, .bus_rx_pin, .bus_tx_pin,
    .tx_pullup_en, .core_tx, .core_rx, .core_clk_en, .tx_enable, .rx_enable,
    .ack_err_ignore, .auto_retx_en, .tx_order_by_request, .timestamp_en, .ttc_timer,
    .filter_active, .wakeup_irq, .debug_halt, .debug_stop_en);
  canmc_bus_node u_node (.bus_tx_pin, .node_dominant(dom), .bus_rx_pin);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task ahb(input logic w, input logic [11:0] a, input logic [31:0] wd,
    output logic [31:0] rdat);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= canmc_pkg::HTRANS_NONSEQ;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rdat = hrdata;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask
  task rd(input logic [11:0] a, output logic [31:0] d);
    ahb(1'b0, a, 32'h0, d);
  endtask
  task wait_st(input int b, input logic v);
    logic [31:0] s;
    int n;
    n = 0;
    rd(canmc_pkg::OFS_MASTER_STATUS, s);
    while (s[b] !== v && n < 300) begin
      rd(canmc_pkg::OFS_MASTER_STATUS, s);
      n++;
    end
    chk("status bit", {31'h0, v}, {31'h0, s[b]});
  endtask
  task pins(input logic t, input logic d);
    @(posedge clk);
    core_tx <= t;
    dom <= d;
    repeat (4) @(posedge clk);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset;
    logic [31:0] d;
    rd(canmc_pkg::OFS_MASTER_STATUS, d);
    chk("status", 32'h0000_0802, d);
    rd(canmc_pkg::OFS_MASTER_CTRL, d);
    chk("ctrl", 32'h0000_0002, d);
    rd(12'h100, d);
    chk("unmapped", 32'h0, d);
    wr(canmc_pkg::OFS_BIT_TIMING, 32'hFFFF_FFFF);
    rd(canmc_pkg::OFS_BIT_TIMING, d);
    chk("timing locked", canmc_pkg::RST_BIT_TIMING, d);
    chk("pullup", 32'h0, {31'h0, tx_pullup_en});
    $display("test reset done");
  endtask
  task t_init;
    logic [31:0] d;
    pins(1'b0, 1'b0);
    wr(canmc_pkg::OFS_MASTER_CTRL, 32'h0000_0001);
    wait_st(canmc_pkg::MS_INIT_ACK, 1'b1);
    wait_st(canmc_pkg::MS_SLEEP_ACK, 1'b0);
    chk("traffic", 32'h0, {30'h0, tx_enable, rx_enable});
    chk("tx pin", 32'h1, {31'h0, bus_tx_pin});
    rd(canmc_pkg::OFS_BIT_TIMING, d);
    chk("timing kept", canmc_pkg::RST_BIT_TIMING, d);
    $display("test init done");
  endtask
  task t_sync;
    int t0;
    logic [31:0] d;
    pins(1'b1, 1'b1);
    wr(canmc_pkg::OFS_MASTER_CTRL, 32'h0);
    wait_st(canmc_pkg::MS_INIT_ACK, 1'b0);
    repeat (120) @(posedge clk);
    rd(canmc_pkg::OFS_MASTER_STATUS, d);
    chk("no sync", 32'h0, {31'h0, d[canmc_pkg::MS_SYNCED]});
    @(posedge clk);
    dom <= 1'b0;
    t0 = cyc;
    wait_st(canmc_pkg::MS_SYNCED, 1'b1);
    chk("sync span", 32'h1, {31'h0, (cyc - t0) >= 80 && (cyc - t0) <= 112});
    chk("enables", 32'h2, {30'h0, tx_enable, rx_enable});
    wr(canmc_pkg::OFS_FILTER_ACT, 32'h0000_3FFF);
    chk("filters held", 32'h0, {18'h0, filter_active});
    wr(canmc_pkg::OFS_FILTER_CTRL, 32'h0);
    repeat (2) @(posedge clk);
    chk("filters", 32'h3FFF, {18'h0, filter_active});
    chk("rx on", 32'h1, {31'h0, rx_enable});
    $display("test sync done");
  endtask
  task t_modes;
    logic lb, sl, ex, ep, er;
    logic [31:0] d;
    for (int k = 0; k < 4; k++) begin
      {sl, lb} = 2'((k + 1) % 4);
      wr(canmc_pkg::OFS_MASTER_CTRL, 32'h0000_0001);
      wait_st(canmc_pkg::MS_INIT_ACK, 1'b1);
      wr(canmc_pkg::OFS_BIT_TIMING, canmc_pkg::RST_BIT_TIMING | {sl, lb, 30'h0});
      rd(canmc_pkg::OFS_BIT_TIMING, d);
      chk("mode bits", canmc_pkg::RST_BIT_TIMING | {sl, lb, 30'h0}, d);
      wr(canmc_pkg::OFS_MASTER_CTRL, 32'h0);
      wait_st(canmc_pkg::MS_SYNCED, 1'b1);
      for (int j = 0; j < 2; j++) begin
        pins(j[0], !j[0]);
        ex = sl ? 1'b1 : j[0];
        ep = ex & j[0];
        er = lb ? j[0] : (sl ? ep & j[0] : ep);
        chk("tx pin", {31'h0, ex}, {31'h0, bus_tx_pin});
        chk("core rx", {31'h0, er}, {31'h0, core_rx});
        chk("ack ignore", {31'h0, lb}, {31'h0, ack_err_ignore});
        chk("tx enable", {31'h0, !sl}, {31'h0, tx_enable});
      end
      pins(1'b1, 1'b0);
    end
    $display("test modes done");
  endtask
  task t_sleep;
    logic [31:0] d;
    wr(canmc_pkg::OFS_INT_ENABLE, 32'h0001_0000);
    wr(canmc_pkg::OFS_MASTER_CTRL, 32'h0000_0002);
    wait_st(canmc_pkg::MS_SLEEP_ACK, 1'b1);
    chk("clock", 32'h0, {31'h0, core_clk_en});
    chk("irq idle", 32'h0, {31'h0, wakeup_irq});
    pins(1'b1, 1'b1);
    pins(1'b1, 1'b0);
    chk("irq", 32'h1, {31'h0, wakeup_irq});
    rd(canmc_pkg::OFS_MASTER_STATUS, d);
    chk("still asleep", 32'hA, d & 32'hB);
    wr(canmc_pkg::OFS_MASTER_STATUS, 32'h8);
    repeat (3) @(posedge clk);
    chk("irq clear", 32'h0, {31'h0, wakeup_irq});
    wr(canmc_pkg::OFS_MASTER_CTRL, 32'h0);
    wait_st(canmc_pkg::MS_SLEEP_ACK, 1'b0);
    wait_st(canmc_pkg::MS_SYNCED, 1'b1);
    wr(canmc_pkg::OFS_MASTER_CTRL, 32'h0000_0022);
    wait_st(canmc_pkg::MS_SLEEP_ACK, 1'b1);
    pins(1'b1, 1'b1);
    pins(1'b1, 1'b0);
    wait_st(canmc_pkg::MS_SLEEP_ACK, 1'b0);
    rd(canmc_pkg::OFS_MASTER_CTRL, d);
    chk("auto clear", 32'h0000_0020, d);
    chk("irq auto", 32'h1, {31'h0, wakeup_irq});
    wr(canmc_pkg::OFS_MASTER_STATUS, 32'h8);
    wait_st(canmc_pkg::MS_SYNCED, 1'b1);
    $display("test sleep done");
  endtask
  task t_debug;
    logic [15:0] t;
    wr(canmc_pkg::OFS_MASTER_CTRL, 32'h0001_0084);
    repeat (3) @(posedge clk);
    chk("time mode", 32'h2, {30'h0, timestamp_en, auto_retx_en});
    chk("tx order", 32'h1, {31'h0, tx_order_by_request});
    t = ttc_timer;
    repeat (40) @(posedge clk);
    chk("timer", {16'h0, t + 16'h5}, {16'h0, ttc_timer});
    @(posedge clk);
    debug_halt <= 1'b1;
    debug_stop_en <= 1'b1;
    repeat (3) @(posedge clk);
    chk("frozen", 32'h0, {30'h0, core_clk_en, tx_enable});
    t = ttc_timer;
    repeat (16) @(posedge clk);
    chk("timer held", {16'h0, t}, {16'h0, ttc_timer});
    debug_stop_en <= 1'b0;
    repeat (3) @(posedge clk);
    chk("running", 32'h3, {30'h0, core_clk_en, tx_enable});
    debug_halt <= 1'b0;
    wr(canmc_pkg::OFS_MASTER_CTRL, 32'h0000_0010);
    repeat (2) @(posedge clk);
    chk("no retx", 32'h0, {31'h0, auto_retx_en});
    wr(canmc_pkg::OFS_MASTER_CTRL, 32'h0);
    repeat (2) @(posedge clk);
    chk("retx", 32'h1, {31'h0, auto_retx_en});
    $display("test debug done");
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    {rst, hsel, hwrite, dom, debug_halt, debug_stop_en} = 6'h20;
    core_tx = 1'b1;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    {err_count, checks, cyc} = '0;
    repeat (8) @(posedge clk);
    chk("pullup reset", 32'h1, {31'h0, tx_pullup_en});
    rst <= 1'b0;
    t_reset;
    t_init;
    t_sync;
    t_modes;
    t_sleep;
    t_debug;
    finish_test;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    finish_test;
  end
endmodule
bind canmc_mode_ctrl canmc_mode_ctrl_sva #(.TIMER_WIDTH(TIMER_WIDTH)) u_sva (.clk, .rst,
  .hsel, .htrans, .hready, .hreadyout, .hresp, .hrdata, .bus_tx_pin, .tx_pullup_en,
  .core_tx, .core_rx, .core_clk_en, .tx_enable, .rx_enable, .ack_err_ignore,
  .auto_retx_en, .timestamp_en, .ttc_timer);
